// ---- hdl/pcxi_pkg.sv ----
// Purpose: Shared constants for the external and pin-change interrupt flag block
// Assumes: Byte-wide register port, word index addressing
// Notes: Offsets are register indices on the plain register port
package pcxi_pkg;
    localparam int PCXI_AW = 4;
    localparam int PCXI_DW = 8;
    // Register indices
    localparam logic [3:0] PCXI_OFF_EXT_FLAGS = 4'h0;
    localparam logic [3:0] PCXI_OFF_EXT_MASK = 4'h1;
    localparam logic [3:0] PCXI_OFF_EXT_CTRL = 4'h2;
    localparam logic [3:0] PCXI_OFF_GRP_ENABLE = 4'h3;
    localparam logic [3:0] PCXI_OFF_GRP_FLAGS = 4'h4;
    localparam logic [3:0] PCXI_OFF_MASK_LOW = 4'h5;
    localparam logic [3:0] PCXI_OFF_MASK_MID = 4'h6;
    localparam logic [3:0] PCXI_OFF_MASK_HIGH = 4'h7;
    localparam logic [3:0] PCXI_OFF_IRQ_STATUS = 4'h8;
    localparam logic [3:0] PCXI_OFF_IRQ_MASK = 4'h9;
    // Field layout
    localparam int PCXI_EXT_A_BIT = 0;
    localparam int PCXI_EXT_B_BIT = 1;
    localparam int PCXI_GRP_LOW_BIT = 0;
    localparam int PCXI_GRP_MID_BIT = 1;
    localparam int PCXI_GRP_HIGH_BIT = 2;
    localparam logic [7:0] PCXI_GRP_USED = 8'h07;
    localparam logic [7:0] PCXI_MASK_MID_USED = 8'h7f;
    localparam logic [7:0] PCXI_EXT_USED = 8'h03;
    // Reset values
    localparam logic [7:0] PCXI_RST_BYTE = 8'h00;
    // Sense modes of an external line
    typedef enum logic [1:0] {
        PCXI_SENSE_LEVEL,
        PCXI_SENSE_ANY,
        PCXI_SENSE_FALL,
        PCXI_SENSE_RISE
    } pcxi_sense_type;
endpackage

// ---- hdl/pcxi_change_det.sv ----
// Purpose: Edge and change detector for a group of synchronous pins
// Assumes: Pins already synchronous to core_clk
// Notes: Change output is combinational against the sample taken one cycle earlier
`timescale 1ns/100ps
module pcxi_change_det
    import pcxi_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] prev_out,
    output logic [WIDTH-1:0] change_out
);
    logic [WIDTH-1:0] prev_reg;

    // Previous sample; reset to low so a high pin at reset reads as change
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            prev_reg <= '0;
        end else begin
            prev_reg <= pin_in;
        end
    end

    assign prev_out = prev_reg;
    assign change_out = pin_in ^ prev_reg;
endmodule

// ---- hdl/pcxi_irq_flags.sv ----
// Purpose: External line and pin-change interrupt flags with vector requests
// Assumes: Core supplies global enable and one-cycle vector acknowledges
// Notes: Register read data stands one cycle after the read strobe
`timescale 1ns/100ps
// Contract
// - Edge or change on line B sets flag bit 1, line A bit 0.
// - Line flag requests its vector only with global enable and line mask.
// - Line flag clears on its vector acknowledge or on write of one.
// - Line flag held at zero while its line is level sensitive.
// - Group enable and group flag bits 7..3 read as zero.
// - Enabled group with global enable raises its vector on unmasked pin change.
// - Change on a pin with its mask bit set, in an enabled group, sets that group's flag bit.
// - Group flag requests its vector only with global and group enable.
// - Group flag clears on acknowledge or write of one; zero leaves it.
// - Pin detects change only while its mask bit and group enable are set.
// - Middle mask bit 7 is read-only zero, seven pins only.
module pcxi_irq_flags
    import pcxi_pkg::*;
(
    // Clock, reset and register port
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // External lines and pin groups
    input wire logic ext_line_a,
    input wire logic ext_line_b,
    input wire logic [7:0] low_group_pins,
    input wire logic [6:0] middle_group_pins,
    input wire logic [7:0] high_group_pins,
    // Core side: global enable and acknowledges
    input wire logic global_irq_enable,
    input wire logic ack_ext_line_a,
    input wire logic ack_ext_line_b,
    input wire logic ack_low_group,
    input wire logic ack_middle_group,
    input wire logic ack_high_group,
    // Vector requests and summary interrupt
    output logic ext_line_a_vector,
    output logic ext_line_b_vector,
    output logic low_group_vector,
    output logic middle_group_vector,
    output logic high_group_vector,
    output logic irq
);
    // Software-visible state
    logic [1:0] ext_flag_reg;
    logic [1:0] ext_line_mask_reg;
    logic [3:0] ext_ctrl_reg;
    logic [2:0] grp_enable_reg;
    logic [2:0] grp_flag_reg;
    logic [7:0] mask_low_reg;
    logic [6:0] mask_mid_reg;
    logic [7:0] mask_high_reg;
    logic [4:0] irq_status_reg;
    logic [4:0] irq_mask_reg;

    // Registered outputs
    logic [7:0] rdata_reg;
    logic [4:0] vec_reg;
    logic irq_reg;

    // Detector results and decoded events
    logic [1:0] ext_prev;
    logic [1:0] ext_chg;
    logic [7:0] low_chg;
    logic [6:0] mid_chg;
    logic [7:0] high_chg;
    logic [1:0] ext_hit;
    logic [2:0] grp_hit;
    logic [1:0] ext_ack;
    logic [2:0] grp_ack;
    logic wr_ext_flags;
    logic wr_grp_flags;

    // Decode of a write strobe at one index, used for every register
    function automatic logic wr_at(input logic [3:0] off);
        return reg_wr && (reg_addr == off);
    endfunction

    // Sense mode of line n from its two control bits
    function automatic pcxi_sense_type sense_of(input int n);
        return pcxi_sense_type'(ext_ctrl_reg[2*n +: 2]);
    endfunction

    // Change detectors for the two lines and three groups
    pcxi_change_det #(.WIDTH(2)) u_ext_det (
        .core_clk(core_clk), .sys_rst(sys_rst),
        .pin_in({ext_line_b, ext_line_a}), .prev_out(ext_prev), .change_out(ext_chg)
    );
    pcxi_change_det #(.WIDTH(8)) u_low_det (
        .core_clk(core_clk), .sys_rst(sys_rst),
        .pin_in(low_group_pins), .prev_out(), .change_out(low_chg)
    );
    pcxi_change_det #(.WIDTH(7)) u_mid_det (
        .core_clk(core_clk), .sys_rst(sys_rst),
        .pin_in(middle_group_pins), .prev_out(), .change_out(mid_chg)
    );
    pcxi_change_det #(.WIDTH(8)) u_high_det (
        .core_clk(core_clk), .sys_rst(sys_rst),
        .pin_in(high_group_pins), .prev_out(), .change_out(high_chg)
    );

    // Edge qualification per external line; level mode raises no flag event
    generate
        for (genvar n = 0; n < 2; n++) begin : g_ext
            always_comb begin
                case (sense_of(n))
                    PCXI_SENSE_ANY: ext_hit[n] = ext_chg[n];
                    PCXI_SENSE_FALL: ext_hit[n] = ext_chg[n] & ext_prev[n];
                    PCXI_SENSE_RISE: ext_hit[n] = ext_chg[n] & ~ext_prev[n];
                    default: ext_hit[n] = 1'b0;
                endcase
            end
        end
    endgenerate

    // A pin counts only when its mask bit and its group enable are both set
    assign grp_hit[PCXI_GRP_LOW_BIT] = grp_enable_reg[PCXI_GRP_LOW_BIT] & |(low_chg & mask_low_reg);
    assign grp_hit[PCXI_GRP_MID_BIT] = grp_enable_reg[PCXI_GRP_MID_BIT] & |(mid_chg & mask_mid_reg);
    assign grp_hit[PCXI_GRP_HIGH_BIT] = grp_enable_reg[PCXI_GRP_HIGH_BIT] & |(high_chg & mask_high_reg);

    // Acknowledge pulses gathered by line and group number
    assign ext_ack = {ack_ext_line_b, ack_ext_line_a};
    assign grp_ack = {ack_high_group, ack_middle_group, ack_low_group};

    // Write-one-to-clear strobes of the two flag registers
    assign wr_ext_flags = wr_at(PCXI_OFF_EXT_FLAGS);
    assign wr_grp_flags = wr_at(PCXI_OFF_GRP_FLAGS);

    // External line flags: set wins over clear, level mode forces zero
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ext_flag_reg <= '0;
        end else begin
            for (int n = 0; n < 2; n++) begin
                if (sense_of(n) == PCXI_SENSE_LEVEL) begin
                    ext_flag_reg[n] <= 1'b0;
                end else if (ext_hit[n]) begin
                    ext_flag_reg[n] <= 1'b1;
                end else if (ext_ack[n] || (wr_ext_flags && reg_wdata[n])) begin
                    ext_flag_reg[n] <= 1'b0;
                end
            end
        end
    end

    // Group flags: set wins over acknowledge or write-one clear
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            grp_flag_reg <= '0;
        end else begin
            for (int g = 0; g < 3; g++) begin
                if (grp_hit[g]) begin
                    grp_flag_reg[g] <= 1'b1;
                end else if (grp_ack[g] || (wr_grp_flags && reg_wdata[g])) begin
                    grp_flag_reg[g] <= 1'b0;
                end
            end
        end
    end

    // External line mask
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ext_line_mask_reg <= '0;
        end else if (wr_at(PCXI_OFF_EXT_MASK)) begin
            ext_line_mask_reg <= reg_wdata[1:0];
        end
    end

    // Sense mode of both lines
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ext_ctrl_reg <= '0;
        end else if (wr_at(PCXI_OFF_EXT_CTRL)) begin
            ext_ctrl_reg <= reg_wdata[3:0];
        end
    end

    // Group enables; upper bits have no storage
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            grp_enable_reg <= '0;
        end else if (wr_at(PCXI_OFF_GRP_ENABLE)) begin
            grp_enable_reg <= reg_wdata[2:0];
        end
    end

    // Low group pin mask
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            mask_low_reg <= PCXI_RST_BYTE;
        end else if (wr_at(PCXI_OFF_MASK_LOW)) begin
            mask_low_reg <= reg_wdata;
        end
    end

    // Middle group pin mask; top bit dropped on write
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            mask_mid_reg <= PCXI_RST_BYTE[6:0];
        end else if (wr_at(PCXI_OFF_MASK_MID)) begin
            mask_mid_reg <= reg_wdata[6:0];
        end
    end

    // High group pin mask
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            mask_high_reg <= PCXI_RST_BYTE;
        end else if (wr_at(PCXI_OFF_MASK_HIGH)) begin
            mask_high_reg <= reg_wdata;
        end
    end

    // Summary interrupt mask
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            irq_mask_reg <= '0;
        end else if (wr_at(PCXI_OFF_IRQ_MASK)) begin
            irq_mask_reg <= reg_wdata[4:0];
        end
    end

    // Sticky status of vector requests raised; write one to clear, set wins
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            irq_status_reg <= '0;
        end else begin
            for (int i = 0; i < 5; i++) begin
                if (vec_reg[i]) begin
                    irq_status_reg[i] <= 1'b1;
                end else if (wr_at(PCXI_OFF_IRQ_STATUS) && reg_wdata[i]) begin
                    irq_status_reg[i] <= 1'b0;
                end
            end
        end
    end

    // Vector requests registered so every output comes from a flip-flop
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            vec_reg <= '0;
        end else begin
            vec_reg[1:0] <= ext_flag_reg & ext_line_mask_reg & {2{global_irq_enable}};
            vec_reg[4:2] <= grp_flag_reg & grp_enable_reg & {3{global_irq_enable}};
        end
    end

    // Summary level; one cycle behind status, traded for a registered pin
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(irq_status_reg & irq_mask_reg);
        end
    end

    // Outputs straight from their flip-flops
    assign ext_line_a_vector = vec_reg[0];
    assign ext_line_b_vector = vec_reg[1];
    assign low_group_vector = vec_reg[2];
    assign middle_group_vector = vec_reg[3];
    assign high_group_vector = vec_reg[4];
    assign irq = irq_reg;

    // Read data one cycle after the strobe; unmapped and idle read zero
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rdata_reg <= '0;
        end else if (!reg_rd) begin
            rdata_reg <= '0;
        end else if (reg_addr == PCXI_OFF_EXT_FLAGS) begin
            rdata_reg <= {6'h00, ext_flag_reg};
        end else if (reg_addr == PCXI_OFF_EXT_MASK) begin
            rdata_reg <= {6'h00, ext_line_mask_reg};
        end else if (reg_addr == PCXI_OFF_EXT_CTRL) begin
            rdata_reg <= {4'h0, ext_ctrl_reg};
        end else if (reg_addr == PCXI_OFF_GRP_ENABLE) begin
            rdata_reg <= {5'h00, grp_enable_reg};
        end else if (reg_addr == PCXI_OFF_GRP_FLAGS) begin
            rdata_reg <= {5'h00, grp_flag_reg};
        end else if (reg_addr == PCXI_OFF_MASK_LOW) begin
            rdata_reg <= mask_low_reg;
        end else if (reg_addr == PCXI_OFF_MASK_MID) begin
            rdata_reg <= {1'b0, mask_mid_reg};
        end else if (reg_addr == PCXI_OFF_MASK_HIGH) begin
            rdata_reg <= mask_high_reg;
        end else if (reg_addr == PCXI_OFF_IRQ_STATUS) begin
            rdata_reg <= {3'h0, irq_status_reg};
        end else if (reg_addr == PCXI_OFF_IRQ_MASK) begin
            rdata_reg <= {3'h0, irq_mask_reg};
        end else begin
            rdata_reg <= '0;
        end
    end

    // Read data port
    assign reg_rdata = rdata_reg;
endmodule

// ---- tb/pcxi_core_model.sv ----
// Purpose: Core side model giving the global enable and vector acknowledges
// Assumes: Vectors are levels; dly of one or more
// Notes: Acks are one-cycle pulses, dly cycles after a vector is seen
`timescale 1ns/100ps
module pcxi_core_model (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic gie_req,
    input wire logic ack_on,
    input wire logic [3:0] dly,
    input wire logic [4:0] vec,
    output logic gie,
    output logic [4:0] ack
);
    logic gie_reg;
    logic [4:0] ack_reg;
    logic [3:0] cnt_reg [5];
    // Counter restarts on ack, so a vector still up for its drop edge is not taken twice
    always_ff @(posedge core_clk) begin
        gie_reg <= !sys_rst && gie_req;
        for (int i = 0; i < 5; i++) begin
            ack_reg[i] <= !sys_rst && ack_on && vec[i] && cnt_reg[i] == dly && !ack_reg[i];
            cnt_reg[i] <= (sys_rst || !vec[i] || ack_reg[i]) ? 4'h0 : cnt_reg[i] + 4'h1;
        end
    end
    // Gated so the block sees zeros from time zero
    assign gie = gie_reg && !sys_rst;
    assign ack = ack_reg & {5{!sys_rst}};
endmodule

// ---- tb/pcxi_irq_flags_assertions.sv ----
// Purpose: Port-level checks of the interrupt flag block
// Assumes: One clock, synchronous high reset
// Notes: Vector one edge after flag, irq registered from status and mask
`timescale 1ns/100ps
module pcxi_irq_flags_assertions
    import pcxi_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [3:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic ext_line_a,
    input wire logic [7:0] low_group_pins,
    input wire logic global_irq_enable,
    input wire logic ack_ext_line_a,
    input wire logic ack_low_group,
    input wire logic ext_line_a_vector,
    input wire logic ext_line_b_vector,
    input wire logic low_group_vector,
    input wire logic middle_group_vector,
    input wire logic high_group_vector,
    input wire logic irq
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    logic [4:0] vec;
    // All vectors together
    assign vec = {high_group_vector, middle_group_vector, low_group_vector, ext_line_b_vector, ext_line_a_vector};
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside its slot");
    a_grp_rsvd_zero: assert property ($past(reg_rd && (reg_addr == PCXI_OFF_GRP_ENABLE ||
        reg_addr == PCXI_OFF_GRP_FLAGS)) |-> reg_rdata[7:3] == 5'h00) else $error("group bits 7..3 not zero");
    a_mid_mask_top: assert property ($past(reg_rd && reg_addr == PCXI_OFF_MASK_MID) |-> !reg_rdata[7])
        else $error("middle mask bit 7 not zero");
    a_ext_vec_gie: assert property ((ext_line_a_vector || ext_line_b_vector) |-> $past(global_irq_enable))
        else $error("line vector without global enable");
    a_grp_vec_gie: assert property (!global_irq_enable |=> vec[4:2] == 3'h0)
        else $error("group vector without global enable");
    a_ext_ack_clear: assert property (ack_ext_line_a && $stable(ext_line_a) |=> ##1 !ext_line_a_vector)
        else $error("line vector kept after acknowledge");
    a_grp_ack_clear: assert property (ack_low_group && $stable(low_group_pins) |=> ##1 !low_group_vector)
        else $error("group vector kept after acknowledge");
    a_grp_vec_hold: assert property (low_group_vector && global_irq_enable && !$past(ack_low_group) &&
        !$past(reg_wr) |=> low_group_vector) else $error("group vector dropped early");
    a_irq_cause: assert property ($rose(irq) && !$past(reg_wr) && !$past(reg_wr, 2) |-> $past(|vec, 2))
        else $error("irq rose without a vector");
endmodule
bind pcxi_irq_flags pcxi_irq_flags_assertions chk (.core_clk, .sys_rst, .reg_addr, .reg_wr, .reg_rd, .reg_rdata,
    .ext_line_a, .low_group_pins, .global_irq_enable, .ack_ext_line_a, .ack_low_group, .ext_line_a_vector,
    .ext_line_b_vector, .low_group_vector, .middle_group_vector, .high_group_vector, .irq);

// ---- tb/pin_change_ext_irq_flags_bench.sv ----
// Purpose: Self-checking bench for the interrupt flag block
// Assumes: Core model acknowledges vectors
// Notes: Random masks and toggles from a fixed xorshift seed
`timescale 1ns/100ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin errors++; \
    $display("MISMATCH %0t got %h want %h", $time, g, e); end end
module pin_change_ext_irq_flags_bench
    import pcxi_pkg::*;
;
    logic core_clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, ext_line_a = 0, ext_line_b = 0;
    logic gie_req = 0, ack_on = 0, global_irq_enable, irq;
    logic [3:0] reg_addr = 0, dly = 4'h3;
    logic [7:0] reg_wdata = 0, reg_rdata, low_group_pins = 0, high_group_pins = 0, m0, m1, m2, t0, t1, t2, en;
    logic [6:0] middle_group_pins = 0;
    logic [4:0] vec, ack;
    logic [31:0] seed = 32'h5081_af9b;
    int errors = 0, tests_run = 0;
    pcxi_irq_flags uut (.core_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ext_line_a,
        .ext_line_b, .low_group_pins, .middle_group_pins, .high_group_pins, .global_irq_enable,
        .ack_ext_line_a(ack[0]), .ack_ext_line_b(ack[1]), .ack_low_group(ack[2]), .ack_middle_group(ack[3]),
        .ack_high_group(ack[4]), .ext_line_a_vector(vec[0]), .ext_line_b_vector(vec[1]),
        .low_group_vector(vec[2]), .middle_group_vector(vec[3]), .high_group_vector(vec[4]), .irq);
    pcxi_core_model core (.core_clk, .sys_rst, .gie_req, .ack_on, .dly, .vec, .gie(global_irq_enable), .ack);
    // Clock and hang guard
    initial forever #10 core_clk = ~core_clk;
    initial begin
        #200_000;
        errors++;
        summarize();
    end
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    // Line flag after a rise or fall for a sense mode
    function automatic logic hit(input int m, input logic r);
        return m == PCXI_SENSE_ANY || m == (r ? PCXI_SENSE_RISE : PCXI_SENSE_FALL);
    endfunction
    // Group flags: only masked-in toggles of enabled groups count
    function automatic logic [7:0] gexp();
        return {5'h00, en[2] && |(m2 & t2), en[1] && |(m1[6:0] & t1[6:0]), en[0] && |(m0 & t0)};
    endfunction
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    // Data taken at the edge that closes the slot after the strobe
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(posedge core_clk);
        `CHK(reg_rdata, e)
    endtask
    task automatic summarize();
        if (errors == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge core_clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 16; i++) rd(i[3:0], 8'h00);
        wr(PCXI_OFF_GRP_ENABLE, 8'hff);
        rd(PCXI_OFF_GRP_ENABLE, 8'h07);
        wr(PCXI_OFF_MASK_MID, 8'hff);
        rd(PCXI_OFF_MASK_MID, 8'h7f);
        // Every sense mode: both lines rise, line B falls and is checked, then line A falls unchecked
        for (int m = 0; m < 4; m++) begin
            wr(PCXI_OFF_EXT_CTRL, {4'h0, m[1:0], m[1:0]});
            wr(PCXI_OFF_EXT_FLAGS, 8'h03);
            ext_line_a <= 1'b1;
            ext_line_b <= 1'b1;
            rd(PCXI_OFF_EXT_FLAGS, {6'h00, {2{hit(m, 1'b1)}}});
            wr(PCXI_OFF_EXT_FLAGS, 8'h03);
            rd(PCXI_OFF_EXT_FLAGS, 8'h00);
            ext_line_b <= 1'b0;
            rd(PCXI_OFF_EXT_FLAGS, {6'h00, hit(m, 1'b0), 1'b0});
            ext_line_a <= 1'b0;
        end
        // Random enables, masks and toggles with the core idle
        for (int n = 0; n < 40; n++) begin
            en = rnd();
            m0 = rnd();
            m1 = rnd();
            m2 = rnd();
            t0 = rnd();
            t1 = rnd();
            t2 = rnd();
            wr(PCXI_OFF_GRP_ENABLE, en);
            wr(PCXI_OFF_MASK_LOW, m0);
            wr(PCXI_OFF_MASK_MID, m1);
            wr(PCXI_OFF_MASK_HIGH, m2);
            wr(PCXI_OFF_GRP_FLAGS, 8'h07);
            low_group_pins <= low_group_pins ^ t0;
            middle_group_pins <= middle_group_pins ^ t1[6:0];
            high_group_pins <= high_group_pins ^ t2;
            rd(PCXI_OFF_GRP_FLAGS, gexp());
            wr(PCXI_OFF_GRP_FLAGS, 8'h00);
            rd(PCXI_OFF_GRP_FLAGS, gexp());
        end
        // Core enabled: all five vectors taken, irq raised, masked, cleared
        gie_req <= 1'b1;
        ack_on <= 1'b1;
        wr(PCXI_OFF_EXT_CTRL, 8'h05);
        // Line B flag while its line mask is still clear: flag stays, no vector
        ext_line_b <= 1'b1;
        repeat (8) @(posedge core_clk);
        rd(PCXI_OFF_EXT_FLAGS, 8'h02);
        `CHK(vec[1], 1'b0)
        wr(PCXI_OFF_EXT_MASK, 8'h03);
        wr(PCXI_OFF_GRP_ENABLE, 8'h07);
        wr(PCXI_OFF_MASK_LOW, 8'h01);
        wr(PCXI_OFF_MASK_MID, 8'h01);
        wr(PCXI_OFF_MASK_HIGH, 8'h01);
        wr(PCXI_OFF_IRQ_MASK, 8'h1f);
        ext_line_a <= 1'b1;
        ext_line_b <= 1'b1;
        low_group_pins <= low_group_pins ^ 8'h01;
        middle_group_pins <= middle_group_pins ^ 7'h01;
        high_group_pins <= high_group_pins ^ 8'h01;
        repeat (20) @(posedge core_clk);
        rd(PCXI_OFF_EXT_FLAGS, 8'h00);
        rd(PCXI_OFF_GRP_FLAGS, 8'h00);
        rd(PCXI_OFF_IRQ_STATUS, 8'h1f);
        `CHK(irq, 1'b1)
        wr(PCXI_OFF_IRQ_MASK, 8'h00);
        wr(PCXI_OFF_IRQ_STATUS, 8'h1f);
        rd(PCXI_OFF_IRQ_STATUS, 8'h00);
        `CHK(irq, 1'b0)
        // Group flag raised with global enable low, then group enable dropped: no vector
        gie_req <= 1'b0;
        low_group_pins <= low_group_pins ^ 8'h01;
        repeat (4) @(posedge core_clk);
        wr(PCXI_OFF_GRP_ENABLE, 8'h00);
        gie_req <= 1'b1;
        repeat (8) @(posedge core_clk);
        rd(PCXI_OFF_GRP_FLAGS, 8'h01);
        rd(PCXI_OFF_IRQ_STATUS, 8'h00);
        `CHK(vec[2], 1'b0)
        summarize();
    end
endmodule
